// [hdl/salvo_chop_defs.vh]
// salvo_chop_defs.vh - constants shared by the salvo/chop key handler files
// assumes it is included by bare name from every design file that needs it
`ifndef SALVO_CHOP_DEFS_VH
`define SALVO_CHOP_DEFS_VH

// ----
// key classes (key_class_i)
// ----
`define KC_LEVEL 4'h0
`define KC_SOURCE 4'h1
`define KC_TARGET_SELECT_FUNCTION 4'h2
`define KC_SALVO 4'h3
`define KC_CATIDX 4'h4
`define KC_PREV 4'h5
`define KC_NEXT 4'h6
`define KC_PRESET 4'h7
`define KC_CLEAR 4'h8
`define KC_STORE 4'h9
`define KC_SHOWPRS 4'hA
`define KC_TARGET 4'hB
`define KC_SALVOFN 4'hC
`define KC_GUARD 4'hD
`define KC_LOCK 4'hE
`define KC_TAKE 4'hF

// ----
// panel modes (mode_o)
// ----
`define MODE_PRESET_SEL 3'h0
`define MODE_SHOW_PRESET 3'h1
`define MODE_TARGET_SEL 3'h2
`define MODE_DIRECT_TAKE 3'h3
`define MODE_STORE 3'h4
`define MODE_SALVO_SEL 3'h5
`define MODE_CHOP 3'h6

// ----
// request kinds (req_kind_o)
// ----
`define REQ_SALVO 2'h0
`define REQ_SWITCH 2'h1
`define REQ_GUARD 2'h2
`define REQ_LOCK 2'h3

// ----
// widths and timing
// ----
`define SALVO_W 6
`define SALVO_N 64
`define SRC_W 10
`define CLK_HZ 25000000
`define FRAME_HZ 30
`define FRAME_CYC (`CLK_HZ / `FRAME_HZ)
`define BLINK_HZ 2
`define BLINK_CYC (`CLK_HZ / (2 * `BLINK_HZ))

`endif

// [hdl/salvo_scan.v]
// salvo_scan.v - finds the previous or next executable salvo in name order
// assumes salvo indices are already sorted alphabetically by name and that
// the valid mask marks salvos that are current and in the panel's list
`timescale 1ns/10ps
`include "salvo_chop_defs.vh"

module salvo_scan (
    input wire [`SALVO_W-1:0] cur_i,         // index now selected
    input wire [`SALVO_N-1:0] valid_i,       // executable salvo mask
    output reg [`SALVO_W-1:0] prev_o,        // nearest valid below, wraps
    output reg [`SALVO_W-1:0] next_o,        // nearest valid above, wraps
    output wire any_o                        // at least one salvo valid
);

    // ------------------------------------------------------------------
    // circular search
    // ------------------------------------------------------------------
    integer k;
    reg [`SALVO_W-1:0] idx;

    assign any_o = |valid_i;

    // walk inward toward cur; farthest hit assigned first, nearest wins
    always @* begin
        prev_o = cur_i;
        next_o = cur_i;
        idx = cur_i;
        for (k = `SALVO_N - 1; k >= 1; k = k - 1) begin
            idx = cur_i - k[`SALVO_W-1:0];
            if (valid_i[idx]) begin
                prev_o = idx;
            end
            idx = cur_i + k[`SALVO_W-1:0];
            if (valid_i[idx]) begin
                next_o = idx;
            end
        end
    end

endmodule

// [hdl/pulse_timer.v]
// pulse_timer.v - free running divider giving a one-cycle tick and a square wave
// assumes one clock and a synchronous-use reset already released cleanly
`timescale 1ns/10ps

module pulse_timer #(
    parameter integer PERIOD = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    output reg tick_o,                       // one cycle every PERIOD
    output reg wave_o                        // toggles on each tick
);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    reg [23:0] cnt_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 24'h000000;
            tick_o <= 1'b0;
            wave_o <= 1'b0;
        end else if (cnt_q == PERIOD - 1) begin
            cnt_q <= 24'h000000;
            tick_o <= 1'b1;
            wave_o <= ~wave_o;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
            tick_o <= 1'b0;
        end
    end

endmodule

// [hdl/salvo_chop_keys.v]
// salvo_chop_keys.v - key interpreter for the salvo select and chop modes
// assumes key strobes arrive from same-clock scanner logic, the address key
// level and salvo mask come from pins, requests go to a comms block by
// valid/ready
`timescale 1ns/10ps
`include "salvo_chop_defs.vh"

module salvo_chop_keys (
    input wire mclk_i,
    input wire rst_n_i,
    input wire key_stb_i,                    // one-cycle key press strobe
    input wire [3:0] key_class_i,            // key class code
    input wire [`SALVO_W-1:0] key_salvo_i,   // salvo assigned to a salvo key
    input wire [`SRC_W-1:0] key_src_i,       // source assigned to a source key
    input wire addr_held_i,                  // address key level, from a pin
    input wire [`SALVO_N-1:0] salvo_valid_i, // current and listed, from pins
    input wire [2:0] enter_mode_i,           // mode set by other panel logic
    input wire enter_stb_i,                  // strobe for enter_mode_i
    input wire [`SRC_W-1:0] online_src_i,    // on-line source now
    input wire [`SRC_W-1:0] preset_src_i,    // preset source now
    input wire req_ready_i,                  // comms accepts request
    output reg [2:0] mode_o,                 // current panel mode
    output reg req_valid_o,                  // request pending
    output reg [1:0] req_kind_o,             // request kind
    output reg [`SALVO_W-1:0] req_salvo_o,   // salvo to execute
    output reg [`SRC_W-1:0] req_src_o,       // source to put on destination
    output reg [`SALVO_W-1:0] sel_salvo_o,   // salvo shown in preset display
    output reg sel_shown_o,                  // a valid salvo is displayed
    output reg show_addr_o,                  // preset display shows address
    output reg guard_led_o,                  // protect/lock led
    output reg guard_mark_o,                 // '!' before destination name
    output reg lock_mark_o,                  // '*' before destination name
    output reg [`SRC_W-1:0] chop_a_o,        // first chopped source
    output reg [`SRC_W-1:0] chop_b_o,        // second chopped source
    output reg chop_blink_o,                 // blink enable for those keys
    output reg [`SRC_W-1:0] new_preset_o     // preset after a swap
);

    // ----
    // reset release and pin synchronisers
    // ----
    reg rst_s1_q;
    reg rst_n_q;                             // released reset used inside
    reg addr_s1_q;
    reg addr_s2_q;
    reg [`SALVO_N-1:0] val_s1_q;
    reg [`SALVO_N-1:0] val_s2_q;

    // reset asserts at once, releases after two edges
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // two flops on every pin input before any logic reads it
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            addr_s1_q <= 1'b0;
            addr_s2_q <= 1'b0;
            val_s1_q <= {`SALVO_N{1'b0}};
            val_s2_q <= {`SALVO_N{1'b0}};
        end else begin
            addr_s1_q <= addr_held_i;
            addr_s2_q <= addr_s1_q;
            val_s1_q <= salvo_valid_i;
            val_s2_q <= val_s1_q;
        end
    end

    // ----
    // helpers: salvo search, frame tick, blink wave
    // ----
    wire [`SALVO_W-1:0] prev_idx;
    wire [`SALVO_W-1:0] next_idx;
    wire any_valid;
    wire frame_tick;
    wire blink_wave;

    salvo_scan u_scan (
        .cur_i(sel_salvo_o),
        .valid_i(val_s2_q),
        .prev_o(prev_idx),
        .next_o(next_idx),
        .any_o(any_valid)
    );

    pulse_timer #(.PERIOD(`FRAME_CYC)) u_frame (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_q),
        .tick_o(frame_tick),
        .wave_o()
    );

    pulse_timer #(.PERIOD(`BLINK_CYC)) u_blink (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_q),
        .tick_o(),
        .wave_o(blink_wave)
    );

    // ----
    // key handling state
    // ----
    reg [2:0] prior_mode_q;                  // mode to restore after chop
    reg [`SRC_W-1:0] orig_src_q;             // on-line source before chop
    reg [`SRC_W-1:0] cur_on_q;               // on-line source during chop
    reg [`SRC_W-1:0] cur_pre_q;              // preset source during chop
    reg guarded_q;
    reg locked_q;

    wire in_salvo = (mode_o == `MODE_SALVO_SEL);
    wire in_chop = (mode_o == `MODE_CHOP);
    // a new request only when the slot is free; held keys are not queued
    wire slot_free = ~req_valid_o | req_ready_i;
    // a shown salvo that just left the valid list no longer counts
    wire sel_ok = sel_shown_o & val_s2_q[sel_salvo_o];

    // main key interpreter
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_o <= `MODE_PRESET_SEL;
            prior_mode_q <= `MODE_PRESET_SEL;
            req_valid_o <= 1'b0;
            req_kind_o <= `REQ_SALVO;
            req_salvo_o <= {`SALVO_W{1'b0}};
            req_src_o <= {`SRC_W{1'b0}};
            sel_salvo_o <= {`SALVO_W{1'b0}};
            sel_shown_o <= 1'b0;
            guarded_q <= 1'b0;
            locked_q <= 1'b0;
            orig_src_q <= {`SRC_W{1'b0}};
            cur_on_q <= {`SRC_W{1'b0}};
            cur_pre_q <= {`SRC_W{1'b0}};
            new_preset_o <= {`SRC_W{1'b0}};
        end else begin
            // drop request once taken; stays stable until then
            if (req_valid_o && req_ready_i) begin
                req_valid_o <= 1'b0;
            end
            // listed-salvo check on the display
            if (sel_shown_o && !val_s2_q[sel_salvo_o]) begin
                sel_shown_o <= 1'b0;
            end
            if (enter_stb_i) begin
                // other panel logic moves us; chop entry keeps history
                if (enter_mode_i == `MODE_CHOP && !in_chop) begin
                    prior_mode_q <= mode_o;
                    orig_src_q <= online_src_i;
                    cur_on_q <= online_src_i;
                    cur_pre_q <= preset_src_i;
                end
                mode_o <= enter_mode_i;
            end else if (key_stb_i && in_salvo) begin
                case (key_class_i)
                    `KC_SALVO: begin
                        // execute the key's salvo; other data keys fall to default
                        if (slot_free) begin
                            req_valid_o <= 1'b1;
                            req_kind_o <= `REQ_SALVO;
                            req_salvo_o <= key_salvo_i;
                        end
                    end
                    `KC_PREV: begin
                        sel_salvo_o <= sel_shown_o ? prev_idx : next_idx;
                        sel_shown_o <= any_valid;
                    end
                    `KC_NEXT: begin
                        sel_salvo_o <= next_idx;
                        sel_shown_o <= any_valid;
                    end
                    `KC_PRESET: mode_o <= `MODE_PRESET_SEL;
                    `KC_CLEAR: sel_shown_o <= 1'b0;
                    `KC_SHOWPRS: mode_o <= `MODE_SHOW_PRESET;
                    `KC_TARGET: mode_o <= `MODE_TARGET_SEL;
                    `KC_SALVOFN: mode_o <= `MODE_DIRECT_TAKE;
                    `KC_TAKE: begin
                        // take and chop share this class here
                        if (sel_ok && slot_free) begin
                            req_valid_o <= 1'b1;
                            req_kind_o <= `REQ_SALVO;
                            req_salvo_o <= sel_salvo_o;
                        end
                    end
                    default: begin
                        // store, level, source, target_select_function, index: no effect
                    end
                endcase
            end else if (key_stb_i && in_chop) begin
                case (key_class_i)
                    `KC_SOURCE, `KC_TARGET_SELECT_FUNCTION, `KC_SALVO, `KC_CATIDX: begin
                        mode_o <= prior_mode_q;
                    end
                    `KC_PRESET: mode_o <= `MODE_PRESET_SEL;
                    `KC_SHOWPRS: mode_o <= `MODE_SHOW_PRESET;
                    `KC_TARGET: mode_o <= `MODE_TARGET_SEL;
                    `KC_SALVOFN: mode_o <= `MODE_SALVO_SEL;
                    `KC_TAKE: begin
                        // restore original if swapped; a pending request is never overwritten
                        mode_o <= prior_mode_q;
                        if (cur_on_q != orig_src_q && slot_free) begin
                            req_valid_o <= 1'b1;
                            req_kind_o <= `REQ_SWITCH;
                            req_src_o <= orig_src_q;
                            new_preset_o <= cur_on_q;
                        end
                    end
                    default: begin
                        // level, prev, next, clear, store: no effect
                    end
                endcase
            end else if (in_chop && frame_tick && !req_valid_o) begin
                // swap once per frame; a frame is skipped if comms is slow
                req_valid_o <= 1'b1;
                req_kind_o <= `REQ_SWITCH;
                req_src_o <= cur_pre_q;
                new_preset_o <= cur_on_q;
                cur_on_q <= cur_pre_q;
                cur_pre_q <= cur_on_q;
            end
            // guard and lock are honoured in salvo select and chop modes only
            if (key_stb_i && !enter_stb_i && (in_salvo || in_chop)) begin
                if (key_class_i == `KC_GUARD && slot_free) begin
                    guarded_q <= 1'b1;
                    locked_q <= 1'b0;
                    req_valid_o <= 1'b1;
                    req_kind_o <= `REQ_GUARD;
                end else if (key_class_i == `KC_LOCK && slot_free) begin
                    locked_q <= 1'b1;
                    guarded_q <= 1'b0;
                    req_valid_o <= 1'b1;
                    req_kind_o <= `REQ_LOCK;
                end
            end
        end
    end

    // ----
    // display and led outputs, registered
    // ----
    // outputs follow state one cycle later so each is a plain flop
    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            show_addr_o <= 1'b0;
            guard_led_o <= 1'b0;
            guard_mark_o <= 1'b0;
            lock_mark_o <= 1'b0;
            chop_a_o <= {`SRC_W{1'b0}};
            chop_b_o <= {`SRC_W{1'b0}};
            chop_blink_o <= 1'b0;
        end else begin
            // address pin level held; display returns on release
            show_addr_o <= addr_s2_q;
            guard_mark_o <= guarded_q;
            lock_mark_o <= locked_q;
            // steady for protect, blinking for lock
            guard_led_o <= guarded_q | (locked_q & blink_wave);
            chop_a_o <= cur_on_q;
            chop_b_o <= cur_pre_q;
            chop_blink_o <= in_chop & blink_wave;
        end
    end

endmodule

// [testbench/salvo_chop_keys_assertions.sv]
// salvo_chop_keys_assertions.sv - port checker for the salvo/chop key handler
// assumes one clock, and reset released through two flops inside the design
`timescale 1ns/10ps
module salvo_chop_keys_chk (
    input wire mclk_i,
    input wire rst_n_i,
    input wire key_stb_i,
    input wire [3:0] key_class_i,
    input wire [5:0] key_salvo_i,
    input wire addr_held_i,
    input wire [2:0] enter_mode_i,
    input wire enter_stb_i,
    input wire req_ready_i,
    input wire [2:0] mode_o,
    input wire req_valid_o,
    input wire [1:0] req_kind_o,
    input wire [5:0] req_salvo_o,
    input wire [9:0] req_src_o,
    input wire [5:0] sel_salvo_o,
    input wire sel_shown_o,
    input wire show_addr_o,
    input wire guard_led_o,
    input wire guard_mark_o,
    input wire lock_mark_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    reg [3:0] live_q; // waits out the design's own reset synchroniser
    reg [2:0] prior_q; // mode held before chop was entered
    wire tk = key_stb_i && !enter_stb_i; // enter strobe wins over a key
    wire m5 = mode_o == 3'h5;
    wire m6 = mode_o == 3'h6;
    wire free = !req_valid_o || req_ready_i; // request slot can take a key
    // settle shift and prior-mode capture
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live_q <= 4'h0;
            prior_q <= 3'h0;
        end else begin
            live_q <= {live_q[2:0], 1'b1};
            if (enter_stb_i && enter_mode_i == 3'h6) begin
                prior_q <= mode_o;
            end
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!live_q[3]);
    property p_hold;
        req_valid_o && !req_ready_i |=> req_valid_o && $stable(req_kind_o)
            && $stable(req_salvo_o) && $stable(req_src_o);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed while waiting");
    property p_salvo_key;
        tk && m5 && key_class_i == 4'h3 && free |=> req_valid_o && req_kind_o == 2'h0
            && req_salvo_o == $past(key_salvo_i);
    endproperty
    a_salvo_key: assert property (p_salvo_key) else $error("salvo key request wrong");
    property p_take;
        tk && m5 && key_class_i == 4'hF && sel_shown_o && free |=> req_valid_o
            && req_kind_o == 2'h0 && req_salvo_o == $past(sel_salvo_o);
    endproperty
    a_take: assert property (p_take) else $error("take did not execute shown salvo");
    property p_idle_take;
        tk && m5 && key_class_i == 4'hF && !sel_shown_o && !req_valid_o |=> !req_valid_o;
    endproperty
    a_idle_take: assert property (p_idle_take) else $error("take with no salvo sent");
    property p_exits;
        tk && (m5 || m6) && key_class_i inside {4'h7, 4'hA, 4'hB} |=> mode_o ==
            (($past(key_class_i) == 4'h7) ? 3'h0 : $past(key_class_i[2:0]) - 3'h1);
    endproperty
    a_exits: assert property (p_exits) else $error("mode key target wrong");
    property p_salvofn;
        tk && (m5 || m6) && key_class_i == 4'hC |=>
            mode_o == (($past(mode_o) == 3'h5) ? 3'h3 : 3'h5);
    endproperty
    a_salvofn: assert property (p_salvofn) else $error("salvo function target wrong");
    property p_chop_exit;
        tk && m6 && key_class_i inside {4'h1, 4'h2, 4'h3, 4'h4, 4'hF} |=> mode_o == prior_q;
    endproperty
    a_chop_exit: assert property (p_chop_exit) else $error("chop exit mode wrong");
    property p_chop_stay;
        tk && m6 && key_class_i inside {4'h0, 4'h5, 4'h6, 4'h8, 4'h9} |=> m6;
    endproperty
    a_chop_stay: assert property (p_chop_stay) else $error("ignored key left chop");
    property p_clear;
        tk && m5 && key_class_i == 4'h8 |=> !sel_shown_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear kept selection");
    property p_ignore;
        tk && m5 && key_class_i inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h9} |=> m5
            && $stable(sel_salvo_o);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored key had effect");
    property p_addr;
        show_addr_o == $past(addr_held_i, 3);
    endproperty
    a_addr: assert property (p_addr) else $error("address display lag wrong");
    property p_guard;
        tk && (m5 || m6) && key_class_i == 4'hD && free |-> ##2 guard_mark_o
            && !lock_mark_o && guard_led_o;
    endproperty
    a_guard: assert property (p_guard) else $error("protect marks wrong");
    property p_lock;
        tk && (m5 || m6) && key_class_i == 4'hE && free |-> ##2 lock_mark_o && !guard_mark_o;
    endproperty
    a_lock: assert property (p_lock) else $error("lock marks wrong");
endmodule
bind salvo_chop_keys salvo_chop_keys_chk salvo_chop_keys_chk_inst (.mclk_i, .rst_n_i,
    .key_stb_i, .key_class_i, .key_salvo_i, .addr_held_i, .enter_mode_i, .enter_stb_i,
    .req_ready_i, .mode_o, .req_valid_o, .req_kind_o, .req_salvo_o, .req_src_o,
    .sel_salvo_o, .sel_shown_o, .show_addr_o, .guard_led_o, .guard_mark_o, .lock_mark_o);

// [testbench/comms_model.sv]
// comms_model.sv - stand-in for the system controller taking salvo, switch, guard and lock requests
// assumes the key handler's clock and an active-low reset
`timescale 1ns/10ps
module comms_model (
    input wire mclk_i,
    input wire rst_n_i,
    input wire req_valid_i,
    input wire [1:0] req_kind_i,
    input wire [5:0] req_salvo_i,
    input wire [9:0] req_src_i,
    input wire [3:0] lat_i, // cycles before accepting, F stalls forever
    output reg req_ready_o,
    output reg [7:0] acc_cnt_o, // requests taken
    output reg [17:0] acc_last_o // kind, salvo, source of the last one
);
    reg [3:0] wait_q;
    // ready pulses once per request; taken on the edge that sees it high
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_ready_o <= 1'b0;
            wait_q <= 4'h0;
            acc_cnt_o <= 8'h00;
            acc_last_o <= 18'h00000;
        end else if (req_ready_o) begin
            req_ready_o <= 1'b0;
            if (req_valid_i) begin
                acc_cnt_o <= acc_cnt_o + 8'h01;
                acc_last_o <= {req_kind_i, req_salvo_i, req_src_i};
            end
        end else if (req_valid_i && lat_i != 4'hF) begin
            if (wait_q >= lat_i) begin
                req_ready_o <= 1'b1;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// [testbench/salvo_chop_keys_tb_top.sv]
// salvo_chop_keys_tb_top.sv - self-checking bench for the salvo/chop key handler
// assumes the comms model and checker files are compiled before this one
`timescale 1ns/10ps
module salvo_chop_keys_tb_top;
    reg mclk_i, rst_n_i, key_stb_i, addr_held_i, enter_stb_i;
    reg [3:0] key_class_i, lat;
    reg [5:0] key_salvo_i;
    reg [63:0] mask;
    reg [2:0] enter_mode_i;
    reg [9:0] online, preset;
    wire req_ready_i, req_valid_o, sel_shown_o, show_addr_o, led, gmark, lmark, blink;
    wire [2:0] mode_o;
    wire [1:0] kind;
    wire [5:0] rsalvo, sel_salvo_o;
    wire [9:0] rsrc, chop_a, chop_b;
    wire [7:0] cnt;
    wire [17:0] last;
    integer err_count, n_compared, nacc, i;
    salvo_chop_keys salvo_chop_keys_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .key_stb_i(key_stb_i), .key_class_i(key_class_i), .key_salvo_i(key_salvo_i),
        .key_src_i(10'h000), .addr_held_i(addr_held_i), .salvo_valid_i(mask),
        .enter_mode_i(enter_mode_i), .enter_stb_i(enter_stb_i), .online_src_i(online),
        .preset_src_i(preset), .req_ready_i(req_ready_i), .mode_o(mode_o),
        .req_valid_o(req_valid_o), .req_kind_o(kind), .req_salvo_o(rsalvo),
        .req_src_o(rsrc), .sel_salvo_o(sel_salvo_o), .sel_shown_o(sel_shown_o),
        .show_addr_o(show_addr_o), .guard_led_o(led), .guard_mark_o(gmark),
        .lock_mark_o(lmark), .chop_a_o(chop_a), .chop_b_o(chop_b),
        .chop_blink_o(blink), .new_preset_o());
    comms_model comms_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_o), .req_kind_i(kind), .req_salvo_i(rsalvo),
        .req_src_i(rsrc), .lat_i(lat), .req_ready_o(req_ready_i), .acc_cnt_o(cnt),
        .acc_last_o(last));
    // ----
    // shared tasks
    // ----
    task automatic chk(input string nm, input [17:0] seen, input [17:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // one-cycle strobe, then let marks and requests settle
    task automatic key(input [3:0] c, input [5:0] s);
        begin
            @(negedge mclk_i);
            key_class_i = c;
            key_salvo_i = s;
            key_stb_i = 1'b1;
            @(negedge mclk_i);
            key_stb_i = 1'b0;
            repeat (3) @(negedge mclk_i);
        end
    endtask
    task automatic go(input [2:0] m);
        begin
            @(negedge mclk_i);
            enter_mode_i = m;
            enter_stb_i = 1'b1;
            @(negedge mclk_i);
            enter_stb_i = 1'b0;
        end
    endtask
    // bounded wait for the comms side to have taken nacc requests
    task automatic took;
        begin
            for (i = 0; i < 40 && cnt !== nacc[7:0]; i = i + 1) @(negedge mclk_i);
            chk("taken", cnt, nacc);
        end
    endtask
    task automatic step(input [3:0] c, input [5:0] e);
        begin
            key(c, 6'h00);
            chk("sel", {sel_shown_o, sel_salvo_o}, {1'b1, e});
        end
    endtask
    task tally_and_finish;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_modes;
        for (i = 0; i < 8; i = i + 1) begin
            go(i < 4 ? 3'h5 : 3'h6);
            key((i % 4 == 3) ? 4'hC : (i % 4 == 0) ? 4'h7 : 4'h9 + i % 4, 6'h00);
            chk("mode", mode_o, (i % 4 == 3) ? (i < 4 ? 3 : 5) : i % 4);
        end
    endtask
    task automatic t_salvo;
        begin
            go(3'h5);
            step(4'h6, 6'd3);
            step(4'h6, 6'd9);
            step(4'h6, 6'd40);
            step(4'h6, 6'd3);
            step(4'h5, 6'd40);
            step(4'h5, 6'd9);
            key(4'hF, 6'h00);
            nacc = nacc + 1;
            took;
            chk("exec", last[17:10], {2'h0, 6'd9});
            mask[9] = 1'b0;
            repeat (5) @(negedge mclk_i);
            chk("shown", sel_shown_o, 0);
            mask[9] = 1'b1;
            step(4'h6, 6'd40);
            key(4'h8, 6'h00);
            chk("clear", sel_shown_o, 0);
            key(4'hF, 6'h00);
            for (i = 0; i < 5; i = i + 1) key(i == 3 ? 4'h9 : i, 6'd7);
            chk("idle", {cnt, mode_o}, {nacc[7:0], 3'h5});
            key(4'h3, 6'd12);
            nacc = nacc + 1;
            took;
            chk("exec", last[17:10], {2'h0, 6'd12});
            lat = 4'hF;
            key(4'h3, 6'd5);
            key(4'h3, 6'd6);
            chk("held", {req_valid_o, rsalvo}, {1'b1, 6'd5});
            lat = 4'h2;
            nacc = nacc + 1;
            took;
            repeat (8) @(negedge mclk_i);
            chk("drop", {cnt, last[15:10]}, {nacc[7:0], 6'd5});
        end
    endtask
    task automatic t_guard;
        begin
            go(3'h5);
            key(4'hD, 6'h00);
            nacc = nacc + 1;
            took;
            chk("guard_function", {last[17:16], led, gmark, lmark}, 5'b10110);
            go(3'h6);
            key(4'hE, 6'h00);
            nacc = nacc + 1;
            took;
            chk("lock", {last[17:16], gmark, lmark}, 4'b1101);
        end
    endtask
    task automatic t_chop;
        begin
            go(3'h5);
            go(3'h6);
            @(negedge mclk_i);
            chk("chop", {chop_a, chop_b}, {10'h064, 10'h0C8});
            for (i = 0; i < 5; i = i + 1) key(i == 0 ? 4'h0 : i + 4 + (i > 2), 6'h00);
            chk("stay", {cnt, mode_o}, {nacc[7:0], 3'h6});
            for (i = 1; i < 6; i = i + 1) begin
                go(i % 5);
                go(3'h6);
                key(i == 5 ? 4'hF : i, 6'h00);
                chk("back", {cnt, mode_o}, {nacc[7:0], 3'(i % 5)});
            end
            addr_held_i = 1'b1;
            repeat (5) @(negedge mclk_i);
            chk("addr", show_addr_o, 1);
            addr_held_i = 1'b0;
            repeat (5) @(negedge mclk_i);
            chk("addr", show_addr_o, 0);
        end
    endtask
    // ----
    // clock, reset, sequence, watchdog
    // ----
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    initial begin
        {rst_n_i, key_stb_i, addr_held_i, enter_stb_i} = 4'h0;
        {key_class_i, key_salvo_i, enter_mode_i, lat} = 17'h00000;
        mask = 64'h0000_0100_0000_0208; // salvos 3, 9 and 40 usable
        online = 10'h064;
        preset = 10'h0C8;
        {err_count, n_compared, nacc} = 0;
        repeat (6) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        t_modes;
        t_salvo;
        t_guard;
        t_chop;
        tally_and_finish;
    end
    initial begin
        #800000;
        err_count = err_count + 1;
        tally_and_finish;
    end
endmodule
